/* verilog/pae_pkg.sv */
// Package for the PLL analog enable register bank: offsets, fields, reset words.
package pae_pkg;

	// ****************************************************************
	// Register offsets and widths
	// ****************************************************************
	localparam int unsigned PAE_DATA_W = 24;
	localparam int unsigned PAE_ADDR_W = 5;
	localparam logic [4:0] PAE_OFS_ANALOG = 5'h08;
	localparam logic [4:0] PAE_OFS_PUMP = 5'h09;
	localparam logic [4:0] PAE_OFS_PIN_CTRL = 5'h0f;

	// ****************************************************************
	// Reset words
	// ****************************************************************
	localparam logic [23:0] PAE_RST_ANALOG = 24'hc1beff;
	localparam logic [23:0] PAE_RST_PUMP = 24'h403264;
	localparam logic [23:0] PAE_RST_PIN_CTRL = 24'h000000;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned PAE_BIT_PAD_EN = 5;
	localparam int unsigned PAE_BIT_BIAS_EN = 10;
	localparam int unsigned PAE_BIT_HF_REF = 21;
	localparam int unsigned PAE_BIT_FORCE_ON = 7;
	localparam int unsigned PAE_BIT_SDO_ONLY = 6;
	localparam int unsigned PAE_DN_LSB = 0;
	localparam int unsigned PAE_UP_LSB = 7;
	localparam int unsigned PAE_GAIN_W = 7;
	localparam logic [23:0] PAE_MASK_PIN_CTRL = 24'h0000c0;

	// Register access from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [23:0] wdata;
	} pae_req_s;

	// Serial transaction status from the serial front end
	typedef struct packed {
		logic active;
		logic addr_match;
		logic read_phase;
		logic sdo_bit;
	} pae_link_s;

	// Pin selection modes
	typedef enum logic [3:0] {
		PAE_PIN_OFF = 4'b0001,
		PAE_PIN_LOCK = 4'b0010,
		PAE_PIN_SDO = 4'b0100,
		PAE_PIN_REL = 4'b1000
	} pae_pin_e;

endpackage

/* verilog/pae_word_reg.sv */
// One writable configuration word with a reset value and a write mask.
`timescale 1ns/1ps
module pae_word_reg
	import pae_pkg::*;
#(
	parameter int unsigned WIDTH = 24,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0,
	parameter logic [WIDTH-1:0] WRITE_MASK = '1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	// Stored word
	output logic [WIDTH-1:0] value
);

	// Storage; each write clears bits outside the mask, while reset loads RESET_VALUE unmasked
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			value <= RESET_VALUE;
		end else if (wr_en) begin
			value <= wr_data & WRITE_MASK;
		end
	end

endmodule

/* verilog/pae_regs.sv */
// Analog enable, charge pump gain and shared lock / serial out pin control.
`timescale 1ns/1ps

// Summary of operation
// - Pad enable clear disables shared pin
// - Pad enable and force bit: always driven
// - Otherwise release driver on foreign chip address
// - Bit ten gates buffer and prescaler bias
// - Pump down and up gains from fields
// - Pin shows lock, serial data during reads or while the data-only bit is set
module pae_regs
	import pae_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register access from serial front end
	input wire pae_req_s req,
	output logic [23:0] rdata,
	output logic rvalid,
	// Serial transaction status and lock flag
	input wire pae_link_s link,
	input wire logic lock_flag,
	// Shared lock / serial out pin
	output logic lock_or_serial_out_pin,
	output logic serial_out_driver_oe_n,
	// Analog controls
	output logic [23:0] analog_enable_word,
	output logic bias_enable,
	output logic high_freq_ref,
	output logic [6:0] pump_down_current_field,
	output logic [6:0] pump_up_current_field
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [23:0] analog_q; // Analog enable word
	logic [23:0] pump_q; // Charge pump word
	logic [23:0] pin_ctrl_q; // Pin control bits only
	logic wr_analog; // Write strobe decodes
	logic wr_pump;
	logic wr_pin;

	assign wr_analog = req.wr && (req.addr == PAE_OFS_ANALOG);
	assign wr_pump = req.wr && (req.addr == PAE_OFS_PUMP);
	assign wr_pin = req.wr && (req.addr == PAE_OFS_PIN_CTRL);

	// Full word kept, reserved bits too, with printed default
	pae_word_reg #(
		.WIDTH(PAE_DATA_W),
		.RESET_VALUE(PAE_RST_ANALOG)
	) u_analog (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(wr_analog),
		.wr_data(req.wdata),
		.value(analog_q)
	);

	// Charge pump gain word
	pae_word_reg #(
		.WIDTH(PAE_DATA_W),
		.RESET_VALUE(PAE_RST_PUMP)
	) u_pump (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(wr_pump),
		.wr_data(req.wdata),
		.value(pump_q)
	);

	// Only the two pin mode bits of this word live in this block
	pae_word_reg #(
		.WIDTH(PAE_DATA_W),
		.RESET_VALUE(PAE_RST_PIN_CTRL),
		.WRITE_MASK(PAE_MASK_PIN_CTRL)
	) u_pin_ctrl (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(wr_pin),
		.wr_data(req.wdata),
		.value(pin_ctrl_q)
	);

	// ****************************************************************
	// Read back
	// ****************************************************************

	// Read data registered; unmapped offsets answer zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata <= 24'h000000;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd) begin
				case (req.addr)
					PAE_OFS_ANALOG: begin
						rdata <= analog_q;
					end
					PAE_OFS_PUMP: begin
						rdata <= pump_q;
					end
					PAE_OFS_PIN_CTRL: begin
						rdata <= pin_ctrl_q;
					end
					default: begin
						rdata <= 24'h000000;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Analog control outputs
	// ****************************************************************

	// Registered copies so outputs come from flops; one cycle behind storage
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			analog_enable_word <= PAE_RST_ANALOG;
			bias_enable <= PAE_RST_ANALOG[PAE_BIT_BIAS_EN];
			high_freq_ref <= PAE_RST_ANALOG[PAE_BIT_HF_REF];
			pump_down_current_field <= PAE_RST_PUMP[PAE_DN_LSB +: PAE_GAIN_W];
			pump_up_current_field <= PAE_RST_PUMP[PAE_UP_LSB +: PAE_GAIN_W];
		end else begin
			analog_enable_word <= analog_q;
			bias_enable <= analog_q[PAE_BIT_BIAS_EN];
			// Host must program this bit for fast crystals
			high_freq_ref <= analog_q[PAE_BIT_HF_REF];
			pump_down_current_field <= pump_q[PAE_DN_LSB +: PAE_GAIN_W];
			pump_up_current_field <= pump_q[PAE_UP_LSB +: PAE_GAIN_W];
		end
	end

	// ****************************************************************
	// Shared pin selection
	// ****************************************************************
	pae_pin_e next_pin_mode; // Pin source for the next cycle
	logic pad_en; // Pad enable bit
	logic force_on; // Keep driver on regardless of address
	logic sdo_only; // Pin dedicated to serial data

	assign pad_en = analog_q[PAE_BIT_PAD_EN];
	assign force_on = pin_ctrl_q[PAE_BIT_FORCE_ON];
	assign sdo_only = pin_ctrl_q[PAE_BIT_SDO_ONLY];

	// Priority: pad off, then foreign-address release, then content select
	always_comb begin
		next_pin_mode = PAE_PIN_LOCK;
		if (!pad_en) begin
			next_pin_mode = PAE_PIN_OFF;
		end else if (!force_on && link.active && !link.addr_match) begin
			// Another part owns the bus, so let go of the line
			next_pin_mode = PAE_PIN_REL;
		end else if (sdo_only || (link.active && link.read_phase)) begin
			next_pin_mode = PAE_PIN_SDO;
		end else begin
			// Force bit keeps driving the lock flag during foreign-address frames with no read phase and the data-only bit clear
			next_pin_mode = PAE_PIN_LOCK;
		end
	end

	// Pin driver; enable is active low, registered to avoid glitches on the pad
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lock_or_serial_out_pin <= 1'b0;
			serial_out_driver_oe_n <= 1'b1;
		end else begin
			case (next_pin_mode)
				PAE_PIN_OFF: begin
					lock_or_serial_out_pin <= 1'b0;
					serial_out_driver_oe_n <= 1'b1;
				end
				PAE_PIN_REL: begin
					lock_or_serial_out_pin <= 1'b0;
					serial_out_driver_oe_n <= 1'b1;
				end
				PAE_PIN_SDO: begin
					lock_or_serial_out_pin <= link.sdo_bit;
					serial_out_driver_oe_n <= 1'b0;
				end
				PAE_PIN_LOCK: begin
					lock_or_serial_out_pin <= lock_flag;
					serial_out_driver_oe_n <= 1'b0;
				end
				default: begin
					lock_or_serial_out_pin <= 1'b0;
					serial_out_driver_oe_n <= 1'b1;
				end
			endcase
		end
	end

endmodule

/* verification/pae_regs_checker.sv */
// Port checker for the analog enable register bank.
`timescale 1ns/1ps
module pae_regs_checker
	import pae_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire pae_req_s req,
	input wire logic [23:0] rdata,
	input wire logic rvalid,
	input wire pae_link_s link,
	input wire logic lock_flag,
	input wire logic lock_or_serial_out_pin,
	input wire logic serial_out_driver_oe_n,
	input wire logic [23:0] analog_enable_word,
	input wire logic bias_enable,
	input wire logic high_freq_ref,
	input wire logic [6:0] pump_down_current_field,
	input wire logic [6:0] pump_up_current_field
);
	logic rst_q; // Reset seen one edge ago; pin outputs still hold reset values then
	always_ff @(posedge clk_sys) rst_q <= rst;
	default clocking cb @(posedge clk_sys); endclocking
	// Skip the release edge too, so no check reads outputs launched under reset
	default disable iff (rst || rst_q);
	logic [23:0] s08; // Shadow of stored analog word
	logic [1:0] s0f; // Shadow of force and data-only bits
	wire oe = serial_out_driver_oe_n;
	wire pin = lock_or_serial_out_pin;
	wire pad = s08[5];
	wire frn = !s0f[1] && link.active && !link.addr_match; // Foreign chip address
	wire rdq = link.active && link.read_phase;
	// Shadows follow writes so pin rules can be judged from ports alone
	always_ff @(posedge clk_sys)
		if (rst) s08 <= PAE_RST_ANALOG;
		else if (req.wr && req.addr == PAE_OFS_ANALOG) s08 <= req.wdata;
	always_ff @(posedge clk_sys)
		if (rst) s0f <= 2'b00;
		else if (req.wr && req.addr == PAE_OFS_PIN_CTRL) s0f <= req.wdata[7:6];
	sequence s_w08; req.wr && req.addr == PAE_OFS_ANALOG; endsequence
	sequence s_w09; req.wr && req.addr == PAE_OFS_PUMP; endsequence
	property p_off; !pad |=> oe && !pin; endproperty
	a_off: assert property (p_off) else $error("pin not off");
	property p_force; pad && s0f[1] |=> !oe; endproperty
	a_force: assert property (p_force) else $error("pin not driven");
	property p_rel; pad && frn |=> oe; endproperty
	a_rel: assert property (p_rel) else $error("driver not released");
	property p_sdo; pad && !frn && (rdq || s0f[0]) |=> !oe && pin == $past(link.sdo_bit);
	endproperty
	a_sdo: assert property (p_sdo) else $error("read data missing");
	property p_lock; pad && !frn && !s0f[0] && !rdq |=> !oe && pin == $past(lock_flag); endproperty
	a_lock: assert property (p_lock) else $error("lock flag missing");
	property p_bias; s_w08 |-> ##2 analog_enable_word == $past(req.wdata, 2) &&
		bias_enable == $past(req.wdata[10], 2) && high_freq_ref == $past(req.wdata[21], 2);
	endproperty
	a_bias: assert property (p_bias) else $error("bias output wrong");
	property p_gain; s_w09 |-> ##2 pump_down_current_field == $past(req.wdata[6:0], 2) &&
		pump_up_current_field == $past(req.wdata[13:7], 2); endproperty
	a_gain: assert property (p_gain) else $error("gain field wrong");
	property p_rb; req.rd && req.addr == PAE_OFS_ANALOG |=> rvalid && rdata == $past(s08);
	endproperty
	a_rb: assert property (p_rb) else $error("readback wrong");
endmodule
bind pae_regs pae_regs_checker pae_regs_checker_i (.clk_sys, .rst, .req, .rdata, .rvalid,
	.link, .lock_flag, .lock_or_serial_out_pin, .serial_out_driver_oe_n, .analog_enable_word,
	.bias_enable, .high_freq_ref, .pump_down_current_field, .pump_up_current_field);

/* verification/pae_host_model.sv */
// Serial front end stand-in driving transaction status.
`timescale 1ns/1ps
module pae_host_model
	import pae_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic act,
	input wire logic mat,
	input wire logic rdp,
	output pae_link_s link
);
	logic sdo; // Toggles every cycle so a stale bit never passes
	always_ff @(posedge clk_sys)
		if (rst) sdo <= 1'b0;
		else sdo <= ~sdo;
	// Foreign addresses and reads are issued on purpose
	assign link = '{act, mat, rdp, sdo};
endmodule

/* verification/pae_regs_tb.sv */
// Self-checking bench for the analog enable register bank.
`timescale 1ns/1ps
module pae_regs_tb;
	import pae_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	pae_req_s req = '0;
	pae_link_s link;
	logic lock_flag = 1'b0, act = 1'b0, mat = 1'b0, rdp = 1'b0;
	logic [23:0] rdata, aw, d;
	logic rvalid, pin, oe_n, bias, hf;
	logic [6:0] dn, up;
	logic [1:0] e;
	logic [31:0] seed = 32'h78416c3a;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	initial forever #12.5 clk_sys = ~clk_sys;
	pae_regs pae_regs_i (.clk_sys, .rst, .req, .rdata, .rvalid, .link, .lock_flag,
		.lock_or_serial_out_pin(pin), .serial_out_driver_oe_n(oe_n), .analog_enable_word(aw),
		.bias_enable(bias), .high_freq_ref(hf), .pump_down_current_field(dn),
		.pump_up_current_field(up));
	pae_host_model pae_host_model_i (.clk_sys, .rst, .act, .mat, .rdp, .link);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Expected {oe_n, pin} in priority order
	function automatic logic [1:0] exp_pin(input logic p, f7, f6, a, m, r, s, l);
		if (!p || (!f7 && a && !m)) return 2'b10;
		if (f6 || (a && r)) return {1'b0, s};
		return {1'b0, l};
	endfunction
	task chk(input logic [23:0] s, input logic [23:0] x);
		tests_run++;
		if (s !== x) begin
			error_cnt++;
			$display("[FAIL] %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task wr(input logic [4:0] a, input logic [23:0] v);
		@(posedge clk_sys);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= v;
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [23:0] x);
		@(posedge clk_sys);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1;
		chk(24'(rvalid), 24'h000001);
		chk(rdata, x);
	endtask
	task test_done;
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(PAE_OFS_ANALOG, PAE_RST_ANALOG);
		rd(PAE_OFS_PUMP, PAE_RST_PUMP);
		rd(5'h03, 24'h000000);
		// Corner words first, then random ones
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			d = (i == 0) ? 24'h000000 : (i == 1) ? 24'hffffff : seed[23:0];
			wr(PAE_OFS_ANALOG, d);
			wr(PAE_OFS_PUMP, ~d);
			#1;
			chk(24'({bias, hf}), 24'({d[10], d[21]}));
			rd(PAE_OFS_ANALOG, d);
			chk({10'h000, up, dn}, {10'h000, ~d[13:0]});
		end
		// Every pad, force and data-only combination under random traffic
		for (int m = 0; m < 8; m++) begin
			seed = xs(seed);
			wr(PAE_OFS_ANALOG, {seed[23:6], m[0], seed[4:0]});
			wr(PAE_OFS_PIN_CTRL, {seed[23:8], m[2:1], seed[5:0]});
			for (int k = 0; k < 40; k++) begin
				@(posedge clk_sys);
				e = exp_pin(m[0], m[2], m[1], act, mat, rdp, link.sdo_bit, lock_flag);
				seed = xs(seed);
				{act, mat, rdp, lock_flag} <= seed[3:0];
				#1;
				chk(24'({oe_n, pin}), 24'(e));
			end
			rd(PAE_OFS_PIN_CTRL, 24'(m[2:1]) << 6);
		end
		test_done();
	end
endmodule
